// ### core/tal_qual.sv
`timescale 1ns/1ps
module tal_qual (
  input wire logic aclk,
  input wire logic aresetn,
  tal_cmp_if.qual  cmp
);
  import tal_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic       trip_hi;
    logic       trip_lo;
  } tal_qst_t;

  tal_qst_t   st_reg;
  tal_qst_t   st_next;
  logic       beyond;
  logic [2:0] need;

  // Side test and consecutive count, once per conversion
  always_comb begin
    st_next = st_reg;
    st_next.trip_hi = 1'b0;
    st_next.trip_lo = 1'b0;
    need = fq_need(cmp.fq);
    beyond = cmp.hot ? (cmp.temp9 < cmp.lo9) : (cmp.temp9 > cmp.hi9);
    if (cmp.done) begin
      if (!beyond) begin
        st_next.cnt = 3'h0;
      end else if (3'(st_reg.cnt + 3'h1) >= need) begin
        st_next.cnt = 3'h0;
        st_next.trip_hi = !cmp.hot;
        st_next.trip_lo = cmp.hot;
      end else begin
        st_next.cnt = 3'(st_reg.cnt + 3'h1);
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cmp.trip_hi = st_reg.trip_hi;
  assign cmp.trip_lo = st_reg.trip_lo;

  a_queue_full: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp.done && !cmp.hot && cmp.temp9 > cmp.hi9 && st_reg.cnt == 3'(need - 3'h1)
    |=> cmp.trip_hi)
    else $error("over-limit queue did not trip");
  a_queue_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp.done && !beyond |=> st_reg.cnt == 3'h0 && !cmp.trip_hi && !cmp.trip_lo)
    else $error("count not cleared on opposite side");
endmodule

// ### core/tal_top.sv
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module tal_top #(
  parameter int unsigned CONV_BASE_CYC = tal_pkg::CONV_9B_CYC,
  parameter int unsigned PWRUP_DLY_CYC = tal_pkg::PWRUP_CYC
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [tal_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [tal_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      sense_clk,
  input  wire logic                      sense_data,
  output logic                           alert_o
);
  import tal_pkg::*;

  typedef enum logic [1:0] {PWRUP, IDLE, CONV} tal_conv_t;

  typedef struct packed {
    logic                   lk_c1;
    logic                   lk_c2;
    logic                   lk_c3;
    logic                   lk_d1;
    logic                   lk_d2;
    logic [TEMP_BITS-1:0]   shift;
    tal_conv_t              state;
    logic [TIMER_W-1:0]     timer;
    logic                   done;
    logic [15:0]            temp;
    logic [7:0]             cfg;
    logic [8:0]             upper;
    logic [8:0]             lower;
    logic [5:0]             ptr;
    logic                   hot;
    logic                   pend;
    logic                   alert;
    logic                   aw_got;
    logic                   w_got;
    logic [ADDR_W-1:0]      awaddr;
    logic [15:0]            wdata;
    logic [1:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } tal_st_t;

  tal_st_t            st_reg;
  tal_st_t            st_next;
  tal_cmp_if          cmp ();
  logic [TIMER_W-1:0] conv_len;
  logic [15:0]        wr_v;
  logic [15:0]        rd_v;
  logic [5:0]         widx;
  logic [5:0]         ridx;
  logic               rd_take;
  logic               clr_pend;
  logic               set_pend;
  logic               act;

  // Handshake outputs
  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;

  // Conversion length doubles per resolution step
  assign conv_len = TIMER_W'(CONV_BASE_CYC) << st_reg.cfg[CFG_RES_LSB +: 2];
  assign widx     = st_reg.awaddr[ADDR_W-1:2];
  assign ridx     = s_axi_araddr[ADDR_W-1:2];

  // Comparison channel feed
  assign cmp.done  = st_reg.done;
  assign cmp.temp9 = st_reg.temp[15:LIM_LSB];
  assign cmp.hi9   = st_reg.upper;
  assign cmp.lo9   = st_reg.lower;
  assign cmp.fq    = st_reg.cfg[CFG_FQ_LSB +: 2];
  assign cmp.hot   = st_reg.hot;

  tal_qual u_qual (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cmp     (cmp)
  );

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    wr_v = 16'h0000;
    rd_v = 16'h0000;
    clr_pend = 1'b0;
    set_pend = 1'b0;
    act = 1'b0;

    // Link sampling, edge found on the second and third stages
    st_next.lk_c1 = sense_clk;
    st_next.lk_c2 = st_reg.lk_c1;
    st_next.lk_c3 = st_reg.lk_c2;
    st_next.lk_d1 = sense_data;
    st_next.lk_d2 = st_reg.lk_d1;
    if (st_reg.lk_c2 && !st_reg.lk_c3) begin
      st_next.shift = {st_reg.shift[TEMP_BITS-2:0], st_reg.lk_d2};
    end

    // Conversion sequencer
    case (st_reg.state)
      PWRUP: begin
        if (st_reg.timer == TIMER_W'(PWRUP_DLY_CYC - 1)) begin
          st_next.state = CONV;
          st_next.timer = '0;
        end else begin
          st_next.timer = TIMER_W'(st_reg.timer + 1'b1);
        end
      end
      IDLE: begin
        st_next.timer = '0;
        if (!st_reg.cfg[CFG_SD] || st_reg.cfg[CFG_OS]) begin
          st_next.state = CONV;
        end
      end
      CONV: begin
        if (st_reg.cfg[CFG_SD] && !st_reg.cfg[CFG_OS]) begin
          st_next.state = IDLE;
          st_next.timer = '0;
        end else if (st_reg.timer == TIMER_W'(conv_len - 1'b1)) begin
          st_next.temp = {st_reg.shift, 4'h0} & res_mask(st_reg.cfg[CFG_RES_LSB +: 2]);
          st_next.done = 1'b1;
          st_next.timer = '0;
          if (st_reg.cfg[CFG_SD]) begin
            st_next.cfg[CFG_OS] = 1'b0;
            st_next.state = IDLE;
          end
        end else begin
          st_next.timer = TIMER_W'(st_reg.timer + 1'b1);
        end
      end
      default: begin
        st_next.state = PWRUP;
        st_next.timer = '0;
      end
    endcase

    // Write address and data, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata[15:0];
      st_next.wstrb = s_axi_wstrb[1:0];
    end
    if (st_reg.aw_got && st_reg.w_got) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      st_next.ptr = widx;
      case (widx)
        IDX_CFG: begin
          wr_v = merge16({8'h00, st_reg.cfg}, st_reg.wdata, st_reg.wstrb);
          st_next.cfg = wr_v[7:0];
          clr_pend = wr_v[CFG_SD] && !st_reg.cfg[CFG_SD];
          // New resolution restarts the conversion, timer never passes a shorter end
          if (st_reg.state == CONV
              && wr_v[CFG_RES_LSB +: 2] != st_reg.cfg[CFG_RES_LSB +: 2]) begin
            st_next.timer = '0;
          end
        end
        IDX_LOWER: begin
          wr_v = merge16({st_reg.lower, 7'h00}, st_reg.wdata, st_reg.wstrb);
          st_next.lower = wr_v[15:LIM_LSB];
        end
        IDX_UPPER: begin
          wr_v = merge16({st_reg.upper, 7'h00}, st_reg.wdata, st_reg.wstrb);
          st_next.upper = wr_v[15:LIM_LSB];
        end
        IDX_TEMP, IDX_PTR: begin
          st_next.bresp = RESP_OKAY;
        end
        default: begin
          st_next.bresp = RESP_SLVERR;
          st_next.ptr = st_reg.ptr;
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Read channel, a taken read acknowledges the event alert
    if (rd_take) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.ptr = ridx;
      clr_pend = 1'b1;
      case (ridx)
        IDX_TEMP:  rd_v = st_reg.temp;
        IDX_CFG:   rd_v = {8'h00, st_reg.cfg};
        IDX_LOWER: rd_v = {st_reg.lower, 7'h00};
        IDX_UPPER: rd_v = {st_reg.upper, 7'h00};
        IDX_PTR:   rd_v = {10'h000, st_reg.ptr};
        default: begin
          st_next.rresp = RESP_SLVERR;
          st_next.ptr = st_reg.ptr;
        end
      endcase
      st_next.rdata = {16'h0000, rd_v};
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // Side tracking, release only during continuous conversion or in event mode
    if (cmp.trip_hi) begin
      st_next.hot = 1'b1;
    end
    if (cmp.trip_lo && (st_reg.cfg[CFG_INT] || !st_reg.cfg[CFG_SD])) begin
      st_next.hot = 1'b0;
    end

    // Event flag, a new event wins over its clear
    set_pend = cmp.trip_hi || cmp.trip_lo;
    if (clr_pend) begin
      st_next.pend = 1'b0;
    end
    if (set_pend) begin
      st_next.pend = 1'b1;
    end

    // Output style and polarity
    act = st_next.cfg[CFG_INT] ? st_next.pend : st_next.hot;
    st_next.alert = st_next.cfg[CFG_POL] ? act : !act;
  end

  // State register with power-on defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.state <= PWRUP;
      st_reg.cfg <= CFG_RST;
      st_reg.temp <= TEMP_RST;
      st_reg.ptr <= PTR_RST;
      st_reg.upper <= UPPER_RST;
      st_reg.lower <= LOWER_RST;
      st_reg.alert <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp  = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata  = st_reg.rdata;
  assign s_axi_rresp  = st_reg.rresp;
  assign alert_o      = st_reg.alert;

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_vals: assert property ($rose(aresetn) |->
    st_reg.cfg == CFG_RST && st_reg.temp == TEMP_RST && st_reg.upper == UPPER_RST
    && st_reg.lower == LOWER_RST && alert_o)
    else $error("register defaults wrong after reset");
  a_pwrup_wait: assert property (
    $past(st_reg.state) == PWRUP && st_reg.state == CONV
    |-> $past(st_reg.timer) == TIMER_W'(PWRUP_DLY_CYC - 1))
    else $error("first conversion started early");
  a_conv_time: assert property (st_reg.done |->
    $past(st_reg.timer) == TIMER_W'($past(conv_len) - 1'b1))
    else $error("conversion length wrong");
  a_hot_sets: assert property (cmp.trip_hi |=> st_reg.hot ##1 (
    alert_o == (st_reg.cfg[CFG_POL] == (st_reg.cfg[CFG_INT] ? st_reg.pend : 1'b1))))
    else $error("over-limit did not assert alert");
  a_sd_holds: assert property (
    st_reg.hot && !st_reg.cfg[CFG_INT] && st_reg.cfg[CFG_SD] && st_next.cfg[CFG_SD]
    |=> st_reg.hot)
    else $error("thermostat alert dropped in power-down");
  a_read_ack: assert property (
    rd_take && !cmp.trip_hi && !cmp.trip_lo |=> !st_reg.pend && s_axi_rvalid)
    else $error("read did not release event alert");
  a_low_event: assert property (cmp.trip_lo |=> st_reg.pend)
    else $error("below-limit event missing");
  a_sd_release: assert property (
    st_reg.aw_got && st_reg.w_got && widx == IDX_CFG && clr_pend && !set_pend
    |=> !st_reg.pend)
    else $error("power-down did not release event alert");
  a_polarity: assert property (
    st_reg.cfg[CFG_POL] == $past(st_reg.cfg[CFG_POL]) && !$past(st_reg.cfg[CFG_INT])
    && !st_reg.cfg[CFG_INT] && st_reg.hot == $past(st_reg.hot)
    |-> alert_o == (st_reg.cfg[CFG_POL] ~^ st_reg.hot))
    else $error("alert level does not follow polarity");

  c_thermo: cover property (st_reg.hot && !st_reg.cfg[CFG_INT] ##1 !st_reg.hot);
  c_event_ack: cover property (st_reg.pend && rd_take);
  c_one_shot: cover property (st_reg.done && st_reg.cfg[CFG_SD]);
endmodule

// ### include/tal_cmp_if.sv
`timescale 1ns/1ps
// Limit comparison channel between control and fault-queue filter
interface tal_cmp_if;
  logic              done;
  logic signed [8:0] temp9;
  logic signed [8:0] hi9;
  logic signed [8:0] lo9;
  logic [1:0]        fq;
  logic              hot;
  logic              trip_hi;
  logic              trip_lo;
  modport ctl  (output done, temp9, hi9, lo9, fq, hot, input trip_hi, trip_lo);
  modport qual (input done, temp9, hi9, lo9, fq, hot, output trip_hi, trip_lo);
endinterface

// ### include/tal_pkg.sv
package tal_pkg;
  // Timing
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned CONV_9B_MS  = 30;
  localparam int unsigned CONV_9B_CYC = CONV_9B_MS * (CLK_HZ / 1000);
  localparam int unsigned PWRUP_MS    = 2;
  localparam int unsigned PWRUP_CYC   = PWRUP_MS * (CLK_HZ / 1000);
  localparam int          TIMER_W     = 24;
  localparam int          ADDR_W      = 8;
  localparam int          TEMP_BITS   = 12;

  // Register indexes, byte address is index times four
  localparam logic [5:0] IDX_TEMP  = 6'h00;
  localparam logic [5:0] IDX_CFG   = 6'h01;
  localparam logic [5:0] IDX_LOWER = 6'h02;
  localparam logic [5:0] IDX_UPPER = 6'h03;
  localparam logic [5:0] IDX_PTR   = 6'h04;

  // Config field positions
  localparam int CFG_SD      = 0;
  localparam int CFG_INT     = 1;
  localparam int CFG_POL     = 2;
  localparam int CFG_FQ_LSB  = 3;
  localparam int CFG_RES_LSB = 5;
  localparam int CFG_OS      = 7;
  localparam int LIM_LSB     = 7;

  // Reset values
  localparam logic [7:0]  CFG_RST   = 8'h00;
  localparam logic [15:0] TEMP_RST  = 16'h0000;
  localparam logic [8:0]  UPPER_RST = 9'h0a0;
  localparam logic [8:0]  LOWER_RST = 9'h096;
  localparam logic [5:0]  PTR_RST   = 6'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Consecutive conversions per queue code
  function automatic logic [2:0] fq_need(input logic [1:0] code);
    case (code)
      2'h0:    fq_need = 3'h1;
      2'h1:    fq_need = 3'h2;
      2'h2:    fq_need = 3'h4;
      default: fq_need = 3'h6;
    endcase
  endfunction

  // Kept result bits per resolution code
  function automatic logic [15:0] res_mask(input logic [1:0] code);
    case (code)
      2'h0:    res_mask = 16'hff80;
      2'h1:    res_mask = 16'hffc0;
      2'h2:    res_mask = 16'hffe0;
      default: res_mask = 16'hfff0;
    endcase
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  strb);
    merge16 = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction
endpackage

// ### test/tal_sense_model.sv
`timescale 1ns/1ps
// Converter side of the serial temperature link
module tal_sense_model (
  output logic             sense_clk,
  output logic             sense_data,
  input  wire logic        go,
  input  wire logic [11:0] word
);
  // Link clock stands low outside a frame
  initial begin
    sense_clk  = 1'b0;
    sense_data = 1'b0;
  end
  // One frame: twelve bits MSB first, data moves while the clock is low
  always @(posedge go) begin
    for (int i = 11; i >= 0; i--) begin
      sense_data = word[i];
      #160 sense_clk = 1'b1;
      #160 sense_clk = 1'b0;
    end
    // Released line shows the inverse of the last bit
    sense_data = ~sense_data;
  end
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
  import tal_pkg::*;
  localparam int unsigned CB     = 200;
  localparam logic [7:0]  a_temp = {IDX_TEMP, 2'b00};
  localparam logic [7:0]  a_cfg  = {IDX_CFG, 2'b00};
  localparam logic [7:0]  a_lo   = {IDX_LOWER, 2'b00};
  localparam logic [7:0]  a_hi   = {IDX_UPPER, 2'b00};
  localparam logic [7:0]  a_ptr  = {IDX_PTR, 2'b00};
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go;
  logic        awready, wready, bvalid, arready, rvalid, sense_clk, sense_data, alert_o;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [11:0] word;
  int          n_mismatch, checks_done, cycles, t0, t1;

  tal_top #(.CONV_BASE_CYC(CB), .PWRUP_DLY_CYC(10)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sense_clk(sense_clk),
    .sense_data(sense_data), .alert_o(alert_o)
  );
  tal_sense_model conv (.sense_clk(sense_clk), .sense_data(sense_data), .go(go), .word(word));

  // 25 MHz clock
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cycle count and hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic al(input logic e);
    chk({31'h0, alert_o}, {31'h0, e});
  endtask

  // Interval between two alert edges, two cycles of slack
  task automatic gap(input int d, input int e);
    chk((d >= e - 2 && d <= e + 2) ? e : d, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask

  task automatic edge_at(input logic v, output int t);
    int n;
    n = 0;
    while (alert_o !== v && n < 3000) begin
      @(negedge aclk);
      n++;
    end
    t = cycles;
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic       ha, hw, hb;
    logic [1:0] r;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, (a > a_ptr) ? RESP_SLVERR : RESP_OKAY});
  endtask

  // Read and compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic        ha, hr;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end while (!hr);
    rready <= 1'b0;
    chk(d, e);
    chk({30'h0, r}, {30'h0, (a > a_ptr) ? RESP_SLVERR : RESP_OKAY});
  endtask

  // One link frame, twelve bits of 320 ns plus sync margin
  task automatic send(input logic [11:0] w);
    @(posedge aclk);
    word <= w;
    go   <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    cyc(110);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = '0;
    {awaddr, araddr, wdata, word} = '0;
    wstrb = 4'hf;
    {n_mismatch, checks_done, cycles} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Defaults, unmapped address, first result timing
    rd(a_temp, 32'h0000_0000);
    wr(8'h14, 16'h00ff);
    rd(a_cfg, 32'h0000_0000);
    rd(a_lo, 32'h0000_4b00);
    rd(a_hi, 32'h0000_5000);
    rd(8'h14, 32'h0000_0000);
    al(1'b1);
    send(12'h1e0);
    rd(a_temp, 32'h0000_0000);
    cyc(150);
    rd(a_temp, 32'h0000_1e00);
    al(1'b1);
    // Limits, comparator active-low, signed compare
    wr(a_hi, 16'h197f);
    rd(a_hi, 32'h0000_1900);
    wr(a_lo, 16'h1400);
    cyc(250);
    al(1'b0);
    send(12'hf60);
    cyc(450);
    al(1'b1);
    rd(a_temp, 32'h0000_f600);
    for (int i = 0; i < 4; i++) begin
      wr(a_cfg, {9'h000, i[1:0], 5'h04});
      rd(a_cfg, {25'h0, i[1:0], 5'h04});
    end
    // Active-high, synced to conversion ends
    wr(a_cfg, 16'h0004);
    cyc(2);
    al(1'b0);
    send(12'h1e0);
    cyc(250);
    al(1'b1);
    wr(a_lo, 16'h7f80);
    edge_at(1'b0, t1);
    wr(a_lo, 16'h1400);
    edge_at(1'b1, t0);
    gap(t0 - t1, CB);
    send(12'h160);
    cyc(300);
    al(1'b1);
    send(12'h0a0);
    edge_at(1'b0, t1);
    gap(t1 - t0, 3 * CB);
    // Fault queue codes
    wr(a_cfg, 16'h001c);
    send(12'h1e0);
    edge_at(1'b1, t0);
    gap(t0 - t1, 6 * CB);
    wr(a_cfg, 16'h0014);
    send(12'h0a0);
    edge_at(1'b0, t1);
    gap(t1 - t0, 4 * CB);
    wr(a_cfg, 16'h000c);
    send(12'h1e0);
    edge_at(1'b1, t0);
    gap(t0 - t1, 2 * CB);
    // Ten-bit resolution doubles the conversion time
    wr(a_cfg, 16'h0024);
    send(12'h0a0);
    edge_at(1'b0, t1);
    send(12'h1e7);
    edge_at(1'b1, t0);
    gap(t0 - t1, 2 * CB);
    rd(a_temp, 32'h0000_1e40);
    // Power-down keeps a comparator alert
    wr(a_cfg, 16'h0025);
    send(12'h0a0);
    cyc(450);
    al(1'b1);
    rd(a_temp, 32'h0000_1e40);
    rd(a_hi, 32'h0000_1900);
    wr(a_cfg, 16'h0004);
    cyc(450);
    al(1'b0);
    // Event style
    wr(a_cfg, 16'h0006);
    rd(a_cfg, 32'h0000_0006);
    al(1'b0);
    send(12'h1e0);
    cyc(250);
    al(1'b1);
    rd(8'h20, 32'h0000_0000);
    cyc(2);
    al(1'b0);
    cyc(450);
    al(1'b0);
    send(12'h0a0);
    cyc(250);
    al(1'b1);
    rd(a_lo, 32'h0000_1400);
    rd(a_ptr, 32'h0000_0002);
    cyc(2);
    al(1'b0);
    send(12'h1e0);
    cyc(250);
    al(1'b1);
    wr(a_cfg, 16'h0007);
    cyc(2);
    al(1'b0);
    // Reset in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(a_cfg, 32'h0000_0000);
    rd(a_hi, 32'h0000_5000);
    rd(a_lo, 32'h0000_4b00);
    al(1'b1);
    test_done();
  end
endmodule
